// file: pkg/pti_pkg.sv
// Package with constants and carrier types for the pipeline timing interlock.
package pti_pkg;

    // Address stage base and additions, and the execute stage minimum, in clocks.
    localparam logic [4:0] PTI_AU_BASE      = 5'h02;
    localparam logic [4:0] PTI_AU_FP_BASE   = 5'h03;
    localparam logic [4:0] PTI_AU_FP_QUAD   = 5'h02;
    localparam logic [4:0] PTI_AU_BOTH_MEM  = 5'h02;
    localparam logic [4:0] PTI_AU_MEM_REL   = 5'h03;
    localparam logic [4:0] PTI_AU_EXTERNAL  = 5'h08;
    localparam logic [4:0] PTI_AU_SCALED    = 5'h02;
    localparam logic [4:0] PTI_EU_MIN       = 5'h02;

    // Loader field costs, in clocks.
    localparam logic [3:0] PTI_LD_FIELD     = 4'h1;
    localparam logic [3:0] PTI_LD_ODD_DW    = 4'h1;
    localparam logic [3:0] PTI_LD_DBL_IMM   = 4'h2;

    // Dependency stall figures, in clocks.
    localparam logic [3:0] PTI_ST_BASE_N1   = 4'h3;
    localparam logic [3:0] PTI_ST_BASE_N2   = 4'h1;
    localparam logic [3:0] PTI_ST_INDEX_N1  = 4'h1;
    localparam logic [3:0] PTI_ST_WIDEN     = 4'h2;
    localparam logic [3:0] PTI_ST_MEM_N1    = 4'h4;
    localparam logic [3:0] PTI_ST_MEM_N2    = 4'h2;

    // Sizes and operand size codes.
    localparam int         PTI_QUEUE_BYTES  = 8;
    localparam int         PTI_WBUF_DEPTH   = 2;
    localparam logic [1:0] PTI_SZ_BYTE      = 2'h0;
    localparam logic [1:0] PTI_SZ_WORD      = 2'h1;
    localparam logic [1:0] PTI_SZ_DWORD     = 2'h2;
    localparam logic [1:0] PTI_SZ_QUAD      = 2'h3;

    // Addressing mode of one general operand.
    typedef enum logic [2:0] {
        PTI_AM_REG, PTI_AM_IMM, PTI_AM_MEM, PTI_AM_MEM_REL,
        PTI_AM_EXTERNAL, PTI_AM_SCALED, PTI_AM_STACK_TOP
    } pti_mode_t;

    // Loader field kinds.
    typedef enum logic [1:0] {
        PTI_FK_PLAIN, PTI_FK_DWORD, PTI_FK_DBL_IMM
    } pti_field_kind_t;

    // One field presented to the loader.
    typedef struct packed {
        logic            valid;
        pti_field_kind_t kind;
        logic            odd_addr;
        logic            last;
    } pti_field_t;

    // One decoded instruction handed to the address stage.
    typedef struct packed {
        logic       valid;
        pti_mode_t  mode1;
        pti_mode_t  mode2;
        logic       two_ops;
        logic       fp_op;
        logic [1:0] fp_quad_mem;
        logic [4:0] au_extra;
        logic [4:0] eu_time;
        logic       serialize;
        logic       au_stops;
        logic       base_use;
        logic [3:0] base_reg;
        logic       index_use;
        logic [3:0] index_reg;
        logic       src_use;
        logic [3:0] src_reg;
        logic [1:0] src_size;
        logic       dst_use;
        logic [3:0] dst_reg;
        logic [1:0] dst_size;
        logic       mem_rd;
        logic [11:0] rd_addr;
        logic [1:0] rd_size;
        logic       rd_cross;
        logic       mem_wr;
        logic [11:0] wr_addr;
        logic [1:0] wr_size;
        logic       wr_cross;
        logic [3:0] storage_delay;
    } pti_instr_t;

    // Record of a retired-into-execute instruction kept for hazard checks.
    typedef struct packed {
        logic        valid;
        logic        dst_use;
        logic [3:0]  dst_reg;
        logic [1:0]  dst_size;
        logic        au_stops;
        logic        sp_only;
        logic        mem_wr;
        logic [11:0] wr_addr;
        logic [1:0]  wr_size;
        logic        wr_cross;
    } pti_hist_t;

    // Timing report of one advance.
    typedef struct packed {
        logic       valid;
        logic [5:0] basic;
        logic [3:0] dep;
        logic [3:0] storage;
        logic [6:0] effective;
    } pti_report_t;

    // Whole state of the block.
    typedef struct packed {
        logic [3:0]  q_count;
        logic [3:0]  ld_cnt;
        logic        prev_odd_dw;
        logic        ld_done;
        pti_instr_t  hold;
        pti_instr_t  au_ins;
        logic [5:0]  au_cnt;
        logic [4:0]  eu_cnt;
        logic        eu_busy;
        logic        eu_serial;
        logic [3:0]  stall_cnt;
        pti_hist_t   h1;
        pti_hist_t   h2;
        logic [1:0]  wb_count;
        logic [5:0]  adv_cnt;
        logic [3:0]  dep_acc;
        logic        field_ready;
        logic        instr_ready;
        logic        advance;
        logic        stall;
        pti_report_t report;
    } pti_state_t;

endpackage

// file: logic/pti_core.sv
// Pipeline timing and interlock controller for a four-stage instruction pipeline.
`timescale 1ns/100ps

// What this block does
// - Address and execute stages each finish an instruction in 2 clocks at best.
// - Pipeline advances when both address and execute stages are done.
// - Serializing instruction: address stage waits for execute, then adds its own time.
// - Loader takes one instruction field per clock.
// - One extra clock for odd paired double words; double immediate takes 2.
// - Loader has an 8-byte queue and a one-instruction holding buffer.
// - Execute stage has a write buffer for two pending memory results.
// - Address stage base time is 2 clocks plus instruction-specific extras.
// - Floating or coprocessor ops add 3 plus 2 per memory quad word.
// - Two general operands both in memory add 2 clocks.
// - Per operand add 3 memory relative, 8 external, 2 scaled index.
// - Base register written one back stalls 3, two back stalls 1.
// - No register stall for stack-top updates or address-stopping producers.
// - Index register written one back stalls 1, earlier none.
// - Source forwarded freely; wider source than prior destination stalls 2.
// - Integer and floating registers share one interlock compare.
// - Memory hazard on boundary cross, bits 0-11 equal, or 2-11 with word sizes.
// - Memory dependency on previous instruction stalls 4 clocks.
// - Memory dependency two instructions back stalls 2 clocks.
// - All interlocks resolved in hardware with no software involvement.
// - Effective time is basic time plus dependency plus storage delays.
module pti_core (
    // Clock and reset.
    input  wire logic                 clk_sys,
    input  wire logic                 sys_rst,
    // Instruction byte queue fill and drain.
    input  wire logic                 q_push,
    input  wire logic                 q_pop,
    // Loader field stream.
    input  wire pti_pkg::pti_field_t  field_in,
    // Decoded instruction description for the holding buffer.
    input  wire pti_pkg::pti_instr_t  instr_in,
    // Execute stage write buffer drain.
    input  wire logic                 wb_drain,
    // Status toward the front end.
    output logic                      field_ready,
    output logic                      instr_ready,
    output logic [3:0]                q_count,
    output logic                      wb_full,
    // Pipeline events and timing report.
    output logic                      advance,
    output logic                      stall,
    output pti_pkg::pti_report_t      report
);
    import pti_pkg::*;

    pti_state_t s_reg;
    pti_state_t s_next;

    // Address stage time of an instruction from its operation and modes.
    function automatic logic [5:0] au_time(input pti_instr_t i);
        logic [5:0] t;
        t = {1'b0, PTI_AU_BASE} + {1'b0, i.au_extra};
        if (i.fp_op)
        begin
            t = t + {1'b0, PTI_AU_FP_BASE}
                  + {1'b0, PTI_AU_FP_QUAD} * {4'h0, i.fp_quad_mem};
        end
        if (i.two_ops && i.mode1 != PTI_AM_REG && i.mode1 != PTI_AM_IMM
            && i.mode2 != PTI_AM_REG && i.mode2 != PTI_AM_IMM)
        begin
            t = t + {1'b0, PTI_AU_BOTH_MEM};
        end
        t = t + {1'b0, mode_add(i.mode1)};
        if (i.two_ops)
        begin
            t = t + {1'b0, mode_add(i.mode2)};
        end
        return t;
    endfunction

    // Extra address stage clocks for one addressing mode.
    function automatic logic [4:0] mode_add(input pti_mode_t m);
        logic [4:0] a;
        a = 5'h00;
        unique case (m)
            PTI_AM_MEM_REL:  a = PTI_AU_MEM_REL;
            PTI_AM_EXTERNAL: a = PTI_AU_EXTERNAL;
            PTI_AM_SCALED:   a = PTI_AU_SCALED;
            default:         a = 5'h00;
        endcase
        return a;
    endfunction

    // Memory read-after-write match between a read and an older write.
    function automatic logic mem_hit(input pti_instr_t i, input pti_hist_t h);
        logic hit;
        hit = 1'b0;
        if (h.valid && h.mem_wr && i.mem_rd)
        begin
            hit = i.rd_cross || h.wr_cross
                || (i.rd_addr == h.wr_addr)
                || ((i.rd_addr[11:2] == h.wr_addr[11:2])
                    && (i.rd_size != PTI_SZ_BYTE || h.wr_size != PTI_SZ_BYTE));
        end
        return hit;
    endfunction

    // Register match; one register file number space for integer and floating.
    function automatic logic reg_hit(input logic use_r, input logic [3:0] r,
                                     input pti_hist_t h);
        return use_r && h.valid && h.dst_use && !h.sp_only && !h.au_stops
               && (h.dst_reg == r);
    endfunction

    // Dependency stall of an instruction entering the address stage.
    function automatic logic [3:0] dep_stall(input pti_instr_t i, input pti_hist_t a,
                                             input pti_hist_t b);
        logic [3:0] d;
        d = 4'h0;
        if (reg_hit(i.base_use, i.base_reg, a))
            d = PTI_ST_BASE_N1;
        else if (reg_hit(i.base_use, i.base_reg, b))
            d = PTI_ST_BASE_N2;
        if (reg_hit(i.index_use, i.index_reg, a) && d < PTI_ST_INDEX_N1)
            d = PTI_ST_INDEX_N1;
        if (reg_hit(i.src_use, i.src_reg, a) && i.src_size > a.dst_size
            && d < PTI_ST_WIDEN)
            d = PTI_ST_WIDEN;
        if (mem_hit(i, a))
            d = PTI_ST_MEM_N1;
        else if (mem_hit(i, b) && d < PTI_ST_MEM_N2)
            d = PTI_ST_MEM_N2;
        return d;
    endfunction

    // Next-state logic for the whole pipeline control.
    always_comb
    begin
        logic       au_done;
        logic       eu_done;
        logic       can_adv;
        logic       take_fld;
        logic [3:0] fld_cost;
        logic [5:0] new_au;
        logic [3:0] new_dep;
        pti_hist_t  nh;
        au_done  = 1'b0;
        eu_done  = 1'b0;
        can_adv  = 1'b0;
        take_fld = 1'b0;
        fld_cost = 4'h0;
        new_au   = 6'h00;
        new_dep  = 4'h0;
        nh       = '0;
        s_next   = s_reg;
        s_next.report.valid = 1'b0;

        // Byte queue occupancy, capped at its size.
        if (q_push && !q_pop && s_reg.q_count < 4'(PTI_QUEUE_BYTES))
            s_next.q_count = s_reg.q_count + 4'h1;
        else if (q_pop && !q_push && s_reg.q_count != 4'h0)
            s_next.q_count = s_reg.q_count - 4'h1;

        // Loader: one field per clock, extra clocks for odd pairs and double immediates.
        if (s_reg.ld_cnt != 4'h0)
        begin
            s_next.ld_cnt = s_reg.ld_cnt - 4'h1;
        end
        else if (field_in.valid && !s_reg.ld_done)
        begin
            take_fld = 1'b1;
            fld_cost = PTI_LD_FIELD;
            if (field_in.kind == PTI_FK_DBL_IMM)
                fld_cost = PTI_LD_DBL_IMM;
            else if (field_in.kind == PTI_FK_DWORD && field_in.odd_addr && s_reg.prev_odd_dw)
                fld_cost = PTI_LD_FIELD + PTI_LD_ODD_DW;
            s_next.ld_cnt      = fld_cost - 4'h1;
            s_next.prev_odd_dw = (field_in.kind == PTI_FK_DWORD) && field_in.odd_addr;
            if (field_in.last)
                s_next.ld_done = 1'b1;
        end

        // Holding buffer takes the decoded instruction once its fields are in.
        if (!s_reg.hold.valid && s_reg.ld_done && s_reg.ld_cnt == 4'h0 && instr_in.valid)
        begin
            s_next.hold    = instr_in;
            s_next.ld_done = 1'b0;
        end

        // Stage counters; a stage is done when its count is spent.
        if (s_reg.stall_cnt != 4'h0)
            s_next.stall_cnt = s_reg.stall_cnt - 4'h1;
        else if (s_reg.au_cnt > 6'h01 && !(s_reg.eu_serial && s_reg.eu_busy))
            s_next.au_cnt = s_reg.au_cnt - 6'h01;
        if (s_reg.eu_cnt > 5'h01)
            s_next.eu_cnt = s_reg.eu_cnt - 5'h01;
        au_done = s_reg.stall_cnt == 4'h0 && s_reg.au_cnt <= 6'h01
                  && !(s_reg.eu_serial && s_reg.eu_busy);
        eu_done = !s_reg.eu_busy || s_reg.eu_cnt <= 5'h01;
        // Execute frees itself even with a waiting address stage, or a serializer deadlocks.
        if (s_reg.eu_busy && s_reg.eu_cnt <= 5'h01)
        begin
            s_next.eu_busy   = 1'b0;
            s_next.eu_serial = 1'b0;
        end
        if (s_reg.adv_cnt != 6'h3F)
            s_next.adv_cnt = s_reg.adv_cnt + 6'h01;

        // Advance when both stages are done and the write buffer has room.
        can_adv = s_reg.au_ins.valid && au_done && eu_done
                  && !(s_reg.au_ins.mem_wr && s_reg.wb_count == 2'(PTI_WBUF_DEPTH));
        if (can_adv)
        begin
            nh.valid    = 1'b1;
            nh.dst_use  = s_reg.au_ins.dst_use;
            nh.dst_reg  = s_reg.au_ins.dst_reg;
            nh.dst_size = s_reg.au_ins.dst_size;
            nh.au_stops = s_reg.au_ins.au_stops || s_reg.au_ins.serialize;
            nh.sp_only  = s_reg.au_ins.mode1 == PTI_AM_STACK_TOP
                          || s_reg.au_ins.mode2 == PTI_AM_STACK_TOP;
            nh.mem_wr   = s_reg.au_ins.mem_wr;
            nh.wr_addr  = s_reg.au_ins.wr_addr;
            nh.wr_size  = s_reg.au_ins.wr_size;
            nh.wr_cross = s_reg.au_ins.wr_cross;
            s_next.h2   = s_reg.h1;
            s_next.h1   = nh;
            s_next.eu_busy   = 1'b1;
            s_next.eu_serial = s_reg.au_ins.serialize;
            s_next.eu_cnt    = (s_reg.au_ins.eu_time < PTI_EU_MIN) ? PTI_EU_MIN
                               : s_reg.au_ins.eu_time;
            s_next.report.valid     = 1'b1;
            s_next.report.basic     = s_reg.adv_cnt + 6'h01 - 6'(s_reg.dep_acc);
            s_next.report.dep       = s_reg.dep_acc;
            s_next.report.storage   = s_reg.au_ins.storage_delay;
            s_next.report.effective = 7'(s_reg.adv_cnt + 6'h01)
                                      + 7'(s_reg.au_ins.storage_delay);
            s_next.adv_cnt  = 6'h00;
            s_next.au_ins   = '0;
        end

        // Address stage loads the held instruction when it is free.
        if ((!s_reg.au_ins.valid || can_adv) && s_reg.hold.valid)
        begin
            new_au  = au_time(s_reg.hold);
            new_dep = can_adv ? dep_stall(s_reg.hold, nh, s_reg.h1)
                              : dep_stall(s_reg.hold, s_reg.h1, s_reg.h2);
            s_next.au_ins    = s_reg.hold;
            s_next.au_cnt    = (new_au < 6'(PTI_EU_MIN)) ? 6'(PTI_EU_MIN) : new_au;
            s_next.stall_cnt = new_dep;
            s_next.dep_acc   = new_dep;
            // Basic time counts from entry, so a starved pipeline does not inflate it.
            s_next.adv_cnt   = 6'h00;
            s_next.hold      = '0;
        end

        // Write buffer occupancy.
        if (can_adv && s_reg.au_ins.mem_wr && !(wb_drain && s_reg.wb_count != 2'h0))
            s_next.wb_count = s_reg.wb_count + 2'h1;
        else if (!(can_adv && s_reg.au_ins.mem_wr) && wb_drain && s_reg.wb_count != 2'h0)
            s_next.wb_count = s_reg.wb_count - 2'h1;

        // Registered status outputs.
        s_next.field_ready = !s_next.ld_done && s_next.ld_cnt == 4'h0;
        s_next.instr_ready = !s_next.hold.valid;
        s_next.advance     = can_adv;
        s_next.stall       = s_next.stall_cnt != 4'h0;
    end

    // State register with synchronous reset.
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end

    // Outputs taken straight from the state register.
    assign field_ready = s_reg.field_ready;
    assign instr_ready = s_reg.instr_ready;
    assign q_count     = s_reg.q_count;
    assign wb_full     = s_reg.wb_count[1]; // Count tops out at two, so bit one is full.
    assign advance     = s_reg.advance;
    assign stall       = s_reg.stall;
    assign report      = s_reg.report;

endmodule

// file: bench/pti_core_properties.sv
// Concurrent checks of the pipeline timing interlock at its ports.
`timescale 1ns/100ps
module pti_core_properties (
    // Clock and reset.
    input wire logic                 clk_sys,
    input wire logic                 sys_rst,
    // Watched inputs.
    input wire logic                 q_push,
    input wire logic                 q_pop,
    input wire pti_pkg::pti_field_t  field_in,
    input wire logic                 wb_drain,
    // Watched outputs.
    input wire logic                 field_ready,
    input wire logic [3:0]           q_count,
    input wire logic                 wb_full,
    input wire logic                 advance,
    input wire logic                 stall,
    input wire pti_pkg::pti_report_t report
);
    import pti_pkg::*;

    // All checks sample on the rising clock and rest during reset.
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    // Advance and report timing.
    a_adv_spacing: assert property (
        advance |=> !advance) else $error("advance on consecutive clocks");
    a_report_pairs: assert property (
        advance == report.valid) else $error("report not paired with advance");
    a_eff_sum: assert property (
        report.valid |-> report.effective == 7'(report.basic) + 7'(report.dep)
        + 7'(report.storage)) else $error("effective time is not the sum");
    a_basic_floor: assert property (
        report.valid |-> report.basic >= 6'h02) else $error("basic time below two");
    a_dep_ceiling: assert property (
        report.valid |-> report.dep <= 4'h4) else $error("stall above four");

    // Queue occupancy follows pushes and pops within its eight bytes.
    a_queue_bound: assert property (
        q_count <= 4'h8) else $error("queue above eight bytes");
    a_queue_fill: assert property (
        q_push && !q_pop && q_count < 4'h8 |=> q_count == $past(q_count) + 4'h1)
        else $error("push did not add one byte");
    a_queue_empty: assert property (
        q_pop && !q_push && q_count == 4'h0 |=> q_count == 4'h0)
        else $error("pop from empty queue changed count");

    // Write buffer and loader timing.
    a_wb_hold: assert property (
        wb_full && !wb_drain |=> wb_full) else $error("full buffer lost an entry");
    a_dbl_imm: assert property (
        field_in.valid && field_ready && field_in.kind == PTI_FK_DBL_IMM && !field_in.last
        |=> !field_ready ##1 field_ready) else $error("double immediate not two clocks");

    // Main scenarios reached.
    c_base_stall: cover property (report.valid && report.dep == 4'h3);
    c_mem_stall: cover property (report.valid && report.dep == 4'h4);
    c_wb_full: cover property (wb_full);
    c_stall: cover property (stall ##1 !stall);
endmodule

bind pti_core pti_core_properties i_pti_core_properties (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .q_push(q_push), .q_pop(q_pop),
    .field_in(field_in), .wb_drain(wb_drain), .field_ready(field_ready),
    .q_count(q_count), .wb_full(wb_full), .advance(advance), .stall(stall),
    .report(report)
);

// file: bench/pti_core_tb.sv
// Self-checking testbench of the pipeline timing interlock.
`timescale 1ns/100ps
module pti_core_tb;
    import pti_pkg::*;

    logic        clk_sys;
    logic        sys_rst;
    logic        q_push;
    logic        q_pop;
    pti_field_t  field_in;
    pti_instr_t  instr_in;
    logic        wb_drain;
    logic        field_ready;
    logic        instr_ready;
    logic [3:0]  q_count;
    logic        wb_full;
    logic        advance;
    logic        stall;
    pti_report_t report;
    int          failures = 0;
    int          num_checks = 0;
    pti_instr_t  hist[$];

    pti_core i_pti_core (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .q_push(q_push), .q_pop(q_pop),
        .field_in(field_in), .instr_in(instr_in), .wb_drain(wb_drain),
        .field_ready(field_ready), .instr_ready(instr_ready), .q_count(q_count),
        .wb_full(wb_full), .advance(advance), .stall(stall), .report(report)
    );

    // Free-running 40 MHz clock.
    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // Prints the counts and the verdict, then stops.
    task automatic give_verdict();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Compares one value and counts it.
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    // Waits at falling edges for field_ready, instr_ready or report valid.
    task automatic await(input int which, input logic lvl);
        int n;
        n = 0;
        while ((which == 0 ? field_ready : which == 1 ? instr_ready : report.valid) !== lvl)
        begin
            @(negedge clk_sys);
            n++;
            if (n > 80)
            begin
                failures++;
                $display("mismatch at %0t: wait ran out", $time);
                give_verdict();
            end
        end
    endtask

    // Extra address clocks of one addressing mode.
    function automatic int ty(pti_mode_t m);
        case (m)
            PTI_AM_MEM_REL:  return 3;
            PTI_AM_EXTERNAL: return 8;
            PTI_AM_SCALED:   return 2;
            default:         return 0;
        endcase
    endfunction

    function automatic int mx(int a, int b);
        return (a > b) ? a : b;
    endfunction

    // Address stage time; execute time is kept at two so it never dominates.
    function automatic int au_time(pti_instr_t i);
        int t;
        t = 2 + i.au_extra + ty(i.mode1);
        if (i.fp_op) t += 3 + 2 * i.fp_quad_mem;
        if (i.two_ops) t += ty(i.mode2) + ((i.mode1 > PTI_AM_IMM && i.mode2 > PTI_AM_IMM) ? 2 : 0);
        return t;
    endfunction

    // Read after write hit, including the false hits on coarse compares.
    function automatic bit mem_hit(pti_instr_t r, pti_instr_t w);
        return r.rd_cross || w.wr_cross || r.rd_addr == w.wr_addr
            || (r.rd_addr[11:2] == w.wr_addr[11:2] && (r.rd_size != 2'h0 || w.wr_size != 2'h0));
    endfunction

    // Largest stall against the two previous instructions, newest first.
    function automatic int dep_of(pti_instr_t i);
        int d;
        pti_instr_t p;
        d = 0;
        for (int k = 0; k < hist.size(); k++)
        begin
            p = hist[k];
            if (p.dst_use && !p.au_stops && !p.serialize)
            begin
                if (i.base_use && i.base_reg == p.dst_reg) d = mx(d, k == 0 ? 3 : 1);
                if (i.index_use && i.index_reg == p.dst_reg && k == 0) d = mx(d, 1);
                if (i.src_use && i.src_reg == p.dst_reg && k == 0 && i.src_size > p.dst_size) d = mx(d, 2);
            end
            if (p.mem_wr && i.mem_rd && mem_hit(i, p)) d = mx(d, k == 0 ? 4 : 2);
        end
        return d;
    endfunction

    // Plain instruction with random extras and storage delay.
    function automatic pti_instr_t mk();
        pti_instr_t i;
        i = '0;
        i.eu_time = 5'h02;
        i.au_extra = 5'($urandom_range(3, 0));
        i.storage_delay = 4'($urandom_range(7, 0));
        return i;
    endfunction

    function automatic pti_instr_t mkp(logic [3:0] r, logic [1:0] sz);
        pti_instr_t i;
        i = mk();
        i.dst_use = 1'b1;
        i.dst_reg = r;
        i.dst_size = sz;
        return i;
    endfunction

    // Consumer kinds: 0 base, 1 index, 2 wide source, 3 byte source.
    function automatic pti_instr_t mkc(int kind, logic [3:0] r);
        pti_instr_t i;
        i = mk();
        i.base_reg = r;
        i.index_reg = r;
        i.src_reg = r;
        i.src_size = (kind == 3) ? PTI_SZ_BYTE : PTI_SZ_DWORD;
        case (kind)
            0:       i.base_use = 1'b1;
            1:       i.index_use = 1'b1;
            default: i.src_use = 1'b1;
        endcase
        return i;
    endfunction

    function automatic pti_instr_t mkm(bit wr, logic [11:0] ad, logic [1:0] sz);
        pti_instr_t i;
        i = mk();
        i.mem_wr = wr;
        i.mem_rd = !wr;
        i.wr_addr = ad;
        i.rd_addr = ad;
        i.wr_size = sz;
        i.rd_size = sz;
        return i;
    endfunction

    // Feeds two fields, hands over the instruction and checks its report.
    task automatic issue(input pti_instr_t ins);
        int au;
        int dep;
        for (int f = 0; f < 2; f++)
        begin
            @(negedge clk_sys);
            await(0, 1'b1);
            field_in.valid = 1'b1;
            field_in.kind = (f == 0) ? pti_field_kind_t'($urandom_range(2, 0)) : PTI_FK_PLAIN;
            field_in.odd_addr = 1'($urandom_range(1, 0));
            field_in.last = (f == 1);
            @(negedge clk_sys);
            field_in.valid = 1'b0;
        end
        await(1, 1'b1);
        instr_in = ins;
        instr_in.valid = 1'b1;
        await(1, 1'b0);
        instr_in.valid = 1'b0;
        au = au_time(ins);
        dep = dep_of(ins);
        @(negedge clk_sys);
        check(12'(stall), 12'(dep != 0));
        await(2, 1'b1);
        check(12'(report.basic), 12'(au));
        check(12'(report.dep), 12'(dep));
        check(12'(report.storage), 12'(ins.storage_delay));
        check(12'(report.effective), 12'(au + dep + ins.storage_delay));
        hist.push_front(ins);
        if (hist.size() > 2)
            hist.pop_back();
        @(negedge clk_sys);
    endtask

    // Producer, optional filler, then consumer.
    task automatic pair(input pti_instr_t p, input pti_instr_t c, input int gap);
        issue(p);
        repeat (gap) issue(mk());
        issue(c);
    endtask

    // Main sequence.
    initial
    begin
        pti_instr_t  a;
        logic [11:0] x;
        void'($urandom(28));
        sys_rst = 1'b1;
        q_push = 1'b0;
        q_pop = 1'b0;
        field_in = '0;
        instr_in = '0;
        wb_drain = 1'b0;
        repeat (12) @(negedge clk_sys);
        sys_rst = 1'b0;
        repeat (2) @(negedge clk_sys);
        q_push = 1'b1;
        repeat (10) @(negedge clk_sys);
        check(12'(q_count), 12'h008);
        q_push = 1'b0;
        q_pop = 1'b1;
        repeat (9) @(negedge clk_sys);
        check(12'(q_count), 12'h000);
        q_pop = 1'b0;
        q_push = 1'b1;
        repeat (8) @(negedge clk_sys);
        q_push = 1'b0;
        for (int m = 0; m < 7; m++)
        begin
            a = mk();
            a.mode1 = pti_mode_t'(m);
            issue(a);
        end
        for (int q = 0; q < 3; q++)
        begin
            a = mk();
            a.fp_op = 1'b1;
            a.fp_quad_mem = 2'(q);
            issue(a);
        end
        a = mk();
        a.two_ops = 1'b1;
        a.mode1 = PTI_AM_MEM;
        a.mode2 = PTI_AM_MEM;
        issue(a);
        a.mode1 = PTI_AM_REG;
        a.mode2 = PTI_AM_SCALED;
        issue(a);
        issue(mkm(1, 12'h100, PTI_SZ_DWORD));
        issue(mkm(1, 12'h200, PTI_SZ_DWORD));
        check(12'(wb_full), 12'h001);
        wb_drain = 1'b1;
        repeat (3) @(negedge clk_sys);
        check(12'(wb_full), 12'h000);
        for (int k = 0; k < 4; k++)
            for (int g = 0; g < 2; g++)
                pair(mkp(4'h5, PTI_SZ_BYTE), mkc(k, 4'h5), g);
        a = mkp(4'h6, PTI_SZ_DWORD);
        a.au_stops = 1'b1;
        pair(a, mkc(0, 4'h6), 0);
        a.au_stops = 1'b0;
        a.fp_op = 1'b1;
        pair(a, mkc(0, 4'h6), 0);
        x = 12'($urandom) & 12'hFF0;
        for (int g = 0; g < 2; g++)
            pair(mkm(1, x, PTI_SZ_DWORD), mkm(0, x, PTI_SZ_DWORD), g);
        pair(mkm(1, x, PTI_SZ_BYTE), mkm(0, x + 12'h001, PTI_SZ_BYTE), 0);
        pair(mkm(1, x, PTI_SZ_WORD), mkm(0, x + 12'h002, PTI_SZ_WORD), 0);
        a = mkm(1, x, PTI_SZ_BYTE);
        a.wr_cross = 1'b1;
        pair(a, mkm(0, x + 12'h040, PTI_SZ_BYTE), 0);
        give_verdict();
    end
endmodule
